// ==== hdl/mcie_core.sv ====
// Instruction execute core: accumulator, file registers, status, program counter, sleep
// Notes on behaviour
// - Destination bit 0 writes accumulator, 1 writes addressed file register 0..127.
// - Decrement-skip stores per destination; zero result turns next into no-op.
// - Increment-skip stores per destination; zero result turns next into no-op.
// - Jump loads 11-bit immediate, upper bits from latch, two cycles, no flags.
// - Or literal into accumulator; only zero flag changes.
// - Increment file, store per destination; only zero flag changes.
// - Or accumulator with file, store per destination; only zero flag changes.
// - Shift left: bit 7 to carry, zero in; carry and zero updated.
// - Shift right: bit 0 to carry, zero in; carry and zero updated.
// - Move file to destination, zero updated, one word, one cycle.
// - Rotate right through carry, store per destination; only carry changes.
// - Literal minus accumulator; carry, digit carry as no-borrow, zero updated.
// - File minus accumulator to destination; carry, digit carry, zero updated.
// - File minus accumulator minus borrow; carry, digit carry, zero updated.
// - Sleep clears watchdog and prescaler, sets timeout, clears power-down, stops.
// - After wake run next instruction, then vector to 004h if enabled.
//
// Design decisions made here: the plain strobed port and the address map.
`include "mcie_defines.svh"

module mcie_core
  import mcie_pkg::*;
(
  input  wire logic        i_clk_sys,
  input  wire logic        i_resetn,
  input  wire logic [7:0]  i_addr,
  input  wire logic [15:0] i_wr_data,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  input  wire logic        i_wake,
  output logic [15:0]      o_rd_data,
  output logic [14:0]      o_pc,
  output logic             o_sleeping,
  output logic             o_busy,
  output logic             o_vector_taken
);

  // ****************************************
  // State and decode
  // ****************************************
  mcie_state_s r;
  mcie_state_s next_r;

  mcie_op_e    op;
  logic [6:0]  f_addr;
  logic [7:0]  f_val;
  logic [7:0]  lit;
  logic        dest_file;
  logic        instr_go;
  logic [7:0]  alu_result;
  logic        alu_carry;
  logic        alu_digit;
  logic        alu_zero;
  logic        alu_wr_carry;
  logic        alu_wr_digit;
  logic        alu_wr_zero;
  logic        alu_skip;

  function automatic mcie_op_e decode(input logic [13:0] word);
    mcie_op_e res;
    res = OP_NOP;
    if (word[13:11] == `MCIE_JUMP_PREFIX) begin
      res = OP_JUMP;
    end else if (word == `MCIE_SLEEP_WORD) begin
      res = OP_SLEEP;
    end else begin
      case (word[13:8])
        `MCIE_OPC_SUB_FILE:   res = OP_SUB_FILE;
        `MCIE_OPC_OR_FILE:    res = OP_OR_FILE;
        `MCIE_OPC_MOVE:       res = OP_MOVE;
        `MCIE_OPC_INC:        res = OP_INC;
        `MCIE_OPC_DEC_SKIP:   res = OP_DEC_SKIP;
        `MCIE_OPC_ROT_RIGHT:  res = OP_ROT_RIGHT;
        `MCIE_OPC_INC_SKIP:   res = OP_INC_SKIP;
        `MCIE_OPC_SHIFT_L:    res = OP_SHIFT_L;
        `MCIE_OPC_SHIFT_R:    res = OP_SHIFT_R;
        `MCIE_OPC_OR_LIT:     res = OP_OR_LIT;
        `MCIE_OPC_SUB_BORROW: res = OP_SUB_BORROW;
        `MCIE_OPC_SUB_LIT:    res = OP_SUB_LIT;
        default:              res = OP_NOP;
      endcase
    end
    return res;
  endfunction

  always_comb begin
    op        = decode(i_wr_data[13:0]);
    f_addr    = i_wr_data[6:0];
    f_val     = r.files[f_addr];
    lit       = i_wr_data[7:0];
    dest_file = i_wr_data[`MCIE_DEST_BIT] && (op != OP_OR_LIT) && (op != OP_SUB_LIT);
    instr_go  = i_wr && (i_addr == `MCIE_ADDR_INSTR) && !r.busy && !r.sleeping;
  end

  // ****************************************
  // Arithmetic unit
  // ****************************************
  mcie_alu u_alu (
    .i_op       (op),
    .i_file     (f_val),
    .i_acc      (r.acc),
    .i_lit      (lit),
    .i_carry    (r.carry),
    .o_result   (alu_result),
    .o_carry    (alu_carry),
    .o_digit    (alu_digit),
    .o_zero     (alu_zero),
    .o_wr_carry (alu_wr_carry),
    .o_wr_digit (alu_wr_digit),
    .o_wr_zero  (alu_wr_zero),
    .o_skip     (alu_skip)
  );

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    next_r              = r;
    next_r.wake_s1      = i_wake;
    next_r.wake_s2      = r.wake_s1;
    next_r.rd_data      = 16'h0000;
    next_r.vector_taken = 1'h0;
    next_r.busy         = 1'h0;

    // Watchdog runs only while awake
    if (!r.sleeping) begin
      {next_r.watchdog_counter, next_r.watchdog_prescaler} =
        {r.watchdog_counter, r.watchdog_prescaler} + 16'h0001;
    end

    // Wake leaves sleep, marks next instruction
    if (r.sleeping && r.wake_s2) begin
      next_r.sleeping = 1'h0;
      next_r.woken    = 1'h1;
    end

    // Register reads
    if (i_rd) begin
      if (i_addr[7]) begin
        next_r.rd_data = {8'h00, r.files[i_addr[6:0]]};
      end else begin
        case (i_addr)
          `MCIE_ADDR_ACC: begin
            next_r.rd_data = {8'h00, r.acc};
          end
          `MCIE_ADDR_STATUS: begin
            next_r.rd_data[`MCIE_ST_CARRY]   = r.carry;
            next_r.rd_data[`MCIE_ST_DIGIT]   = r.digit_carry;
            next_r.rd_data[`MCIE_ST_ZERO]    = r.zero;
            next_r.rd_data[`MCIE_ST_PWRDN]   = r.power_down_status;
            next_r.rd_data[`MCIE_ST_TIMEOUT] = r.timeout_status;
          end
          `MCIE_ADDR_PC: begin
            next_r.rd_data = {1'h0, r.pc};
          end
          `MCIE_ADDR_PCLATCH: begin
            next_r.rd_data = {9'h000, r.upper_pc_latch};
          end
          `MCIE_ADDR_CTRL: begin
            next_r.rd_data[`MCIE_CTRL_GIE] = r.global_irq_enable;
          end
          `MCIE_ADDR_STATE: begin
            next_r.rd_data[`MCIE_CS_BUSY]  = r.busy;
            next_r.rd_data[`MCIE_CS_SLEEP] = r.sleeping;
            next_r.rd_data[`MCIE_CS_SKIP]  = r.skip_pending;
            next_r.rd_data[`MCIE_CS_WOKEN] = r.woken;
          end
          `MCIE_ADDR_WATCHDOG: begin
            next_r.rd_data = {r.watchdog_counter, r.watchdog_prescaler};
          end
          default: begin
            next_r.rd_data = 16'h0000;
          end
        endcase
      end
    end

    // Register writes other than instruction issue
    if (i_wr) begin
      if (i_addr[7]) begin
        next_r.files[i_addr[6:0]] = i_wr_data[7:0];
      end else begin
        case (i_addr)
          `MCIE_ADDR_ACC: begin
            next_r.acc = i_wr_data[7:0];
          end
          `MCIE_ADDR_STATUS: begin
            next_r.carry       = i_wr_data[`MCIE_ST_CARRY];
            next_r.digit_carry = i_wr_data[`MCIE_ST_DIGIT];
            next_r.zero        = i_wr_data[`MCIE_ST_ZERO];
          end
          `MCIE_ADDR_PCLATCH: begin
            next_r.upper_pc_latch = i_wr_data[6:0];
          end
          `MCIE_ADDR_CTRL: begin
            next_r.global_irq_enable = i_wr_data[`MCIE_CTRL_GIE];
          end
          default: begin
            next_r.acc = next_r.acc;
          end
        endcase
      end
    end

    // Instruction execution
    if (instr_go) begin
      next_r.pc = r.pc + 15'h0001;
      if (r.skip_pending) begin
        next_r.skip_pending = 1'h0;
      end else begin
        case (op)
          // Jump with upper bits from latch
          OP_JUMP: begin
            next_r.pc   = {r.upper_pc_latch[6:3], i_wr_data[10:0]};
            next_r.busy = 1'h1;
          end
          OP_SLEEP: begin
            next_r.watchdog_counter   = 8'h00;
            next_r.watchdog_prescaler = 8'h00;
            next_r.timeout_status     = 1'h1;
            next_r.power_down_status  = 1'h0;
            next_r.sleeping           = 1'h1;
          end
          OP_NOP: begin
            next_r.pc = r.pc + 15'h0001;
          end
          default: begin
            if (dest_file) begin
              next_r.files[f_addr] = alu_result;
            end else begin
              next_r.acc = alu_result;
            end
            if (alu_wr_carry) begin
              next_r.carry = alu_carry;
            end
            if (alu_wr_digit) begin
              next_r.digit_carry = alu_digit;
            end
            if (alu_wr_zero) begin
              next_r.zero = alu_zero;
            end
            next_r.skip_pending = alu_skip;
          end
        endcase
      end
      // Vector after first instruction past wake
      if (r.woken) begin
        next_r.woken = 1'h0;
        if (r.global_irq_enable) begin
          next_r.pc           = `MCIE_IRQ_VECTOR;
          next_r.vector_taken = 1'h1;
          next_r.busy         = 1'h0;
        end
      end
    end
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      r                   <= '0;
      r.power_down_status <= `MCIE_RST_PWRDN;
      r.timeout_status    <= `MCIE_RST_TIMEOUT;
    end else begin
      r <= next_r;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign o_rd_data      = r.rd_data;
  assign o_pc           = r.pc;
  assign o_sleeping     = r.sleeping;
  assign o_busy         = r.busy;
  assign o_vector_taken = r.vector_taken;

endmodule

// ==== hdl/mcie_defines.svh ====
// Register offsets, field positions, opcode values and reset values of the core
`ifndef MCIE_DEFINES_SVH
`define MCIE_DEFINES_SVH

// ****************************************
// Register offsets
// ****************************************
`define MCIE_ADDR_INSTR     8'h00
`define MCIE_ADDR_ACC       8'h01
`define MCIE_ADDR_STATUS    8'h02
`define MCIE_ADDR_PC        8'h03
`define MCIE_ADDR_PCLATCH   8'h04
`define MCIE_ADDR_CTRL      8'h05
`define MCIE_ADDR_STATE     8'h06
`define MCIE_ADDR_WATCHDOG  8'h07

// ****************************************
// Field positions
// ****************************************
`define MCIE_ST_CARRY       0
`define MCIE_ST_DIGIT       1
`define MCIE_ST_ZERO        2
`define MCIE_ST_PWRDN       3
`define MCIE_ST_TIMEOUT     4
`define MCIE_CTRL_GIE       0
`define MCIE_CS_BUSY        0
`define MCIE_CS_SLEEP       1
`define MCIE_CS_SKIP        2
`define MCIE_CS_WOKEN       3
`define MCIE_DEST_BIT       7

// ****************************************
// Opcode values
// ****************************************
`define MCIE_JUMP_PREFIX    3'h5
`define MCIE_SLEEP_WORD     14'h0063
`define MCIE_OPC_SUB_FILE   6'h02
`define MCIE_OPC_OR_FILE    6'h04
`define MCIE_OPC_MOVE       6'h08
`define MCIE_OPC_INC        6'h0A
`define MCIE_OPC_DEC_SKIP   6'h0B
`define MCIE_OPC_ROT_RIGHT  6'h0C
`define MCIE_OPC_INC_SKIP   6'h0F
`define MCIE_OPC_SHIFT_L    6'h35
`define MCIE_OPC_SHIFT_R    6'h36
`define MCIE_OPC_OR_LIT     6'h38
`define MCIE_OPC_SUB_BORROW 6'h3B
`define MCIE_OPC_SUB_LIT    6'h3C

// ****************************************
// Reset and fixed values
// ****************************************
`define MCIE_IRQ_VECTOR     15'h0004
`define MCIE_RST_PWRDN      1'h1
`define MCIE_RST_TIMEOUT    1'h1

`endif

// ==== hdl/mcie_pkg.sv ====
// Types shared by the instruction execute core
package mcie_pkg;

  typedef enum logic [3:0] {
    OP_NOP,
    OP_MOVE,
    OP_INC,
    OP_OR_FILE,
    OP_DEC_SKIP,
    OP_INC_SKIP,
    OP_ROT_RIGHT,
    OP_SHIFT_L,
    OP_SHIFT_R,
    OP_SUB_FILE,
    OP_SUB_BORROW,
    OP_OR_LIT,
    OP_SUB_LIT,
    OP_JUMP,
    OP_SLEEP
  } mcie_op_e;

  typedef struct packed {
    logic [127:0][7:0] files;
    logic [7:0]        acc;
    logic              carry;
    logic              digit_carry;
    logic              zero;
    logic              power_down_status;
    logic              timeout_status;
    logic [14:0]       pc;
    logic [6:0]        upper_pc_latch;
    logic              global_irq_enable;
    logic [7:0]        watchdog_counter;
    logic [7:0]        watchdog_prescaler;
    logic              sleeping;
    logic              busy;
    logic              skip_pending;
    logic              woken;
    logic              vector_taken;
    logic              wake_s1;
    logic              wake_s2;
    logic [15:0]       rd_data;
  } mcie_state_s;

endpackage

// ==== hdl/mcie_alu.sv ====
// Arithmetic and logic unit for the file register instructions
module mcie_alu
  import mcie_pkg::*;
(
  input  wire mcie_op_e   i_op,
  input  wire logic [7:0] i_file,
  input  wire logic [7:0] i_acc,
  input  wire logic [7:0] i_lit,
  input  wire logic       i_carry,
  output logic [7:0]      o_result,
  output logic            o_carry,
  output logic            o_digit,
  output logic            o_zero,
  output logic            o_wr_carry,
  output logic            o_wr_digit,
  output logic            o_wr_zero,
  output logic            o_skip
);

  logic [8:0] sum;
  logic [4:0] nib;
  logic [7:0] minuend;
  logic       cin;

  // ****************************************
  // Result and flags
  // ****************************************
  always_comb begin
    minuend    = (i_op == OP_SUB_LIT) ? i_lit : i_file;
    cin        = (i_op == OP_SUB_BORROW) ? i_carry : 1'h1;
    sum        = {1'h0, minuend} + {1'h0, ~i_acc} + {8'h00, cin};
    nib        = {1'h0, minuend[3:0]} + {1'h0, ~i_acc[3:0]} + {4'h0, cin};
    o_result   = i_file;
    o_carry    = i_carry;
    o_digit    = 1'h0;
    o_wr_carry = 1'h0;
    o_wr_digit = 1'h0;
    o_wr_zero  = 1'h0;
    o_skip     = 1'h0;
    case (i_op)
      OP_MOVE: begin
        o_wr_zero = 1'h1;
      end
      OP_INC: begin
        o_result  = i_file + 8'h01;
        o_wr_zero = 1'h1;
      end
      OP_OR_FILE: begin
        o_result  = i_file | i_acc;
        o_wr_zero = 1'h1;
      end
      OP_OR_LIT: begin
        o_result  = i_acc | i_lit;
        o_wr_zero = 1'h1;
      end
      OP_DEC_SKIP: begin
        o_result = i_file - 8'h01;
        o_skip   = (o_result == 8'h00);
      end
      OP_INC_SKIP: begin
        o_result = i_file + 8'h01;
        o_skip   = (o_result == 8'h00);
      end
      OP_ROT_RIGHT: begin
        o_result   = {i_carry, i_file[7:1]};
        o_carry    = i_file[0];
        o_wr_carry = 1'h1;
      end
      OP_SHIFT_L: begin
        o_result   = {i_file[6:0], 1'h0};
        o_carry    = i_file[7];
        o_wr_carry = 1'h1;
        o_wr_zero  = 1'h1;
      end
      OP_SHIFT_R: begin
        o_result   = {1'h0, i_file[7:1]};
        o_carry    = i_file[0];
        o_wr_carry = 1'h1;
        o_wr_zero  = 1'h1;
      end
      OP_SUB_LIT, OP_SUB_FILE, OP_SUB_BORROW: begin
        o_result   = sum[7:0];
        o_carry    = sum[8];
        o_digit    = nib[4];
        o_wr_carry = 1'h1;
        o_wr_digit = 1'h1;
        o_wr_zero  = 1'h1;
      end
      default: begin
        o_result = i_file;
      end
    endcase
    o_zero = (o_result == 8'h00);
  end

endmodule

// ==== verif/mcie_core_props.sv ====
// Port-level checks for the instruction execute core
module mcie_core_props (
  input wire logic        i_clk_sys,
  input wire logic        i_resetn,
  input wire logic [7:0]  i_addr,
  input wire logic [15:0] i_wr_data,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic        i_wake,
  input wire logic [15:0] o_rd_data,
  input wire logic [14:0] o_pc,
  input wire logic        o_sleeping,
  input wire logic        o_busy,
  input wire logic        o_vector_taken
);
  // ****************************************
  // Helpers
  // ****************************************
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_resetn);
  logic take;
  assign take = i_wr && i_addr == 8'h00 && !o_busy && !o_sleeping;

  // ****************************************
  // Properties
  // ****************************************
  property p_rd_idle;
    !$past(i_rd) |-> o_rd_data == 16'h0000;
  endproperty
  property p_jump;
    take && i_wr_data[13:11] == 3'h5 |=>
      o_vector_taken || (o_busy && o_pc[10:0] == $past(i_wr_data[10:0]));
  endproperty
  property p_busy_one;
    $rose(o_busy) |=> !o_busy;
  endproperty
  property p_sleep_in;
    take && i_wr_data[13:0] == 14'h0063 |=>
      o_vector_taken || (o_sleeping && o_pc == $past(o_pc) + 15'h0001);
  endproperty
  property p_sleep_hold;
    o_sleeping |=> $stable(o_pc);
  endproperty
  property p_wake;
    $fell(o_sleeping) |-> $past(i_wake, 3);
  endproperty
  property p_vec_pc;
    o_vector_taken |-> o_pc == 15'h0004;
  endproperty
  property p_vec_one;
    o_vector_taken |=> !o_vector_taken;
  endproperty
  property p_step;
    take && i_wr_data[13:8] == 6'h08 |=>
      o_vector_taken || (o_pc == $past(o_pc) + 15'h0001 && !o_busy);
  endproperty

  a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
  a_jump: assert property (p_jump) else $error("jump target wrong");
  a_busy_one: assert property (p_busy_one) else $error("busy too long");
  a_sleep_in: assert property (p_sleep_in) else $error("sleep not entered");
  a_sleep_hold: assert property (p_sleep_hold) else $error("pc moved in sleep");
  a_wake: assert property (p_wake) else $error("woke without request");
  a_vec_pc: assert property (p_vec_pc) else $error("vector address wrong");
  a_vec_one: assert property (p_vec_one) else $error("vector pulse too long");
  a_step: assert property (p_step) else $error("move not one cycle");
  c_jump: cover property (o_busy);
  c_sleep: cover property (o_sleeping);
  c_vec: cover property (o_vector_taken);
endmodule

// ==== verif/tb_mcie_core.sv ====
// Self-checking bench for the instruction execute core
module tb_mcie_core;
  timeunit 1ns;
  timeprecision 1ps;
  logic        i_clk_sys    = 1'b0;
  logic        i_resetn     = 1'b0;
  logic [7:0]  i_addr       = 8'h00;
  logic [15:0] i_wr_data    = 16'h0000;
  logic        i_wr         = 1'b0;
  logic        i_rd         = 1'b0;
  logic        i_wake       = 1'b0;
  logic [15:0] o_rd_data;
  logic [14:0] o_pc;
  logic        o_sleeping;
  logic        o_busy;
  logic        o_vector_taken;
  int          mismatches   = 0;
  int          total_checks = 0;
  logic [14:0] epc          = 15'h0000;
  logic [15:0] v;

  always #12.5 i_clk_sys = ~i_clk_sys;

  mcie_core u_dut (
    .i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_addr(i_addr),
    .i_wr_data(i_wr_data), .i_wr(i_wr), .i_rd(i_rd), .i_wake(i_wake),
    .o_rd_data(o_rd_data), .o_pc(o_pc), .o_sleeping(o_sleeping),
    .o_busy(o_busy), .o_vector_taken(o_vector_taken)
  );

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    i_addr <= a;
    i_wr_data <= d;
    i_wr <= 1'b1;
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
    @(posedge i_clk_sys);
  endtask

  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
    #1;
    d = o_rd_data;
    @(posedge i_clk_sys);
  endtask

  task automatic exec(input logic [13:0] ins);
    wr(8'h00, {2'b00, ins});
    epc = epc + 15'h0001;
  endtask

  task automatic op(input logic [13:0] ins, input logic dst, input logic [7:0] fv,
                    input logic [7:0] av, input logic [2:0] st, input logic [7:0] res,
                    input logic [4:0] est);
    logic [7:0] fa;
    fa = {1'b1, ins[6:0]};
    wr(fa, {8'h00, fv});
    wr(8'h01, {8'h00, av});
    wr(8'h02, {13'h0000, st});
    exec(ins);
    chk({1'b0, o_pc}, {1'b0, epc}); // step
    rd(8'h02, v);
    chk(v, {11'h000, est}); // flags
    rd(8'h01, v);
    chk(v, {8'h00, dst ? av : res}); // acc
    rd(fa, v);
    chk(v, {8'h00, dst ? res : fv}); // file
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    rd(8'h02, v);
    chk(v, 16'h0018); // status
    rd(8'h40, v);
    chk(v, 16'h0000); // unmapped
    chk({1'b0, o_pc}, 16'h0000); // pc
  endtask

  task automatic t_ops();
    op(14'h0AFF, 1'b1, 8'hFF, 8'h00, 3'h3, 8'h00, 5'h1F); // wrap
    op(14'h0410, 1'b0, 8'h0F, 8'hF0, 3'h3, 8'hFF, 5'h1B); // or
    op(14'h3850, 1'b0, 8'h11, 8'h05, 3'h7, 8'h55, 5'h1B); // literal
    op(14'h3590, 1'b1, 8'h81, 8'h33, 3'h0, 8'h02, 5'h19); // left
    op(14'h3510, 1'b0, 8'h80, 8'h33, 3'h2, 8'h00, 5'h1F); // left
    op(14'h3690, 1'b1, 8'h01, 8'h33, 3'h0, 8'h00, 5'h1D); // right
    op(14'h3610, 1'b0, 8'h82, 8'h33, 3'h1, 8'h41, 5'h18); // right
    op(14'h0C10, 1'b0, 8'h02, 8'h33, 3'h5, 8'h81, 5'h1C); // rotate
    op(14'h3C05, 1'b0, 8'h11, 8'h05, 3'h0, 8'h00, 5'h1F); // equal
    op(14'h3C01, 1'b0, 8'h11, 8'h02, 3'h7, 8'hFF, 5'h18); // borrow
    op(14'h0290, 1'b1, 8'h20, 8'h21, 3'h7, 8'hFF, 5'h18); // borrow
    op(14'h3B90, 1'b1, 8'h10, 8'h0F, 3'h0, 8'h00, 5'h1D); // borrow in
    op(14'h3B10, 1'b0, 8'h10, 8'h0F, 3'h1, 8'h01, 5'h19); // no borrow
    op(14'h0810, 1'b0, 8'h00, 8'h55, 3'h3, 8'h00, 5'h1F); // move
    op(14'h0B90, 1'b1, 8'h02, 8'h55, 3'h5, 8'h01, 5'h1D); // no skip
  endtask

  task automatic t_skip();
    op(14'h0B90, 1'b1, 8'h01, 8'h00, 3'h0, 8'h00, 5'h18); // zero
    exec(14'h38FF);
    rd(8'h01, v);
    chk(v, 16'h0000); // skipped
    chk({1'b0, o_pc}, {1'b0, epc}); // pc
    op(14'h0F10, 1'b0, 8'hFF, 8'h00, 3'h0, 8'h00, 5'h18); // zero
    exec(14'h38FF);
    exec(14'h3801);
    rd(8'h01, v);
    chk(v, 16'h0001); // one skipped
  endtask

  task automatic t_jump();
    wr(8'h04, 16'h004D);
    wr(8'h02, 16'h0000);
    i_addr <= 8'h00;
    i_wr_data <= 16'h2DA5;
    i_wr <= 1'b1;
    @(posedge i_clk_sys);
    i_wr_data <= 16'h38FF;
    #1;
    chk({15'h0000, o_busy}, 16'h0001); // busy
    chk({1'b0, o_pc}, 16'h4DA5); // target
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
    #1;
    chk({15'h0000, o_busy}, 16'h0000); // two cycles
    epc = 15'h4DA5;
    @(posedge i_clk_sys);
    rd(8'h01, v);
    chk(v, 16'h0001); // refused
    rd(8'h02, v);
    chk(v, 16'h0018); // no flags
    rd(8'h03, v);
    chk(v, 16'h4DA5); // pc register
  endtask

  task automatic t_sleep();
    int n;
    wr(8'h05, 16'h0001);
    wr(8'h01, 16'h0000);
    exec(14'h0063);
    chk({15'h0000, o_sleeping}, 16'h0001); // asleep
    rd(8'h02, v);
    chk(v & 16'h0018, 16'h0010); // status
    rd(8'h07, v);
    chk(v, 16'h0000); // watchdog
    wr(8'h00, 16'h3880);
    chk({1'b0, o_pc}, {1'b0, epc}); // stopped
    i_wake <= 1'b1;
    for (n = 0; n < 10 && o_sleeping !== 1'b0; n++) @(negedge i_clk_sys);
    if (n == 10) begin
      mismatches++;
      wrap_up();
    end
    @(posedge i_clk_sys);
    i_wake <= 1'b0;
    i_addr <= 8'h00;
    i_wr_data <= 16'h3801;
    i_wr <= 1'b1;
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
    #1;
    chk({15'h0000, o_vector_taken}, 16'h0001); // vector
    chk({1'b0, o_pc}, 16'h0004); // address
    @(posedge i_clk_sys);
    @(negedge i_clk_sys);
    chk({15'h0000, o_vector_taken}, 16'h0000); // one pulse
    @(posedge i_clk_sys);
    rd(8'h01, v);
    chk(v, 16'h0001); // next executed
  endtask

  initial begin
    repeat (8) @(posedge i_clk_sys);
    i_resetn <= 1'b1;
    @(posedge i_clk_sys);
    t_reset();
    t_ops();
    t_skip();
    t_jump();
    t_sleep();
    wrap_up();
  end
endmodule

bind mcie_core mcie_core_props u_props (
  .i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_addr(i_addr),
  .i_wr_data(i_wr_data), .i_wr(i_wr), .i_rd(i_rd), .i_wake(i_wake),
  .o_rd_data(o_rd_data), .o_pc(o_pc), .o_sleeping(o_sleeping),
  .o_busy(o_busy), .o_vector_taken(o_vector_taken)
);
